// *** hw/sense_indicator_flag_unit.sv ***
`timescale 1ns/10ps
module sense_indicator_flag_unit (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 op_start,
    input  wire flag_unit_pkg::op_e   op_code,
    input  wire logic        [0:17]   ctl_field,
    input  wire logic                 mem_valid,
    input  wire logic        [0:35]   mem_word,
    input  wire logic        [0:35]   work_reg_in,
    output logic             [0:35]   program_flag_word_ff,
    output logic             [0:35]   memory_buffer_word_ff,
    output logic                      busy_ff,
    output logic                      done_ff,
    output logic             [0:35]   store_word_ff,
    output logic                      store_we_ff,
    output logic             [0:37]   work_reg_out_ff,
    output logic                      work_reg_we_ff,
    output logic                      jump_valid_ff,
    output logic                      jump_taken_ff
);
    import flag_unit_pkg::*;

    // ==========================================================
    // Internal state
    state_e      state_ff;
    state_e      nxt_state;
    op_e         op_ff;
    op_e         nxt_op;
    logic [0:35] nxt_buffer;
    upd_e        nxt_mode;
    logic [0:35] nxt_flags;
    logic        nxt_done;
    logic        nxt_store_we;
    logic        nxt_work_we;
    logic        nxt_jump_valid;
    logic        take_start;
    logic        field_left;
    logic [0:35] field_word;
    logic [0:35] test_sum;
    logic        test_carry;

    // Requests are only taken while idle; a start while busy is dropped
    assign take_start = op_start && (state_ff == st_idle);

    // ==========================================================
    // Field routing and the test adder
    always_comb begin
        field_left = (op_code == set_left_flags_by_field)
                  || (op_code == clear_left_flags_by_field)
                  || (op_code == invert_left_flags_by_field);
    end

    half_router u_router (
        .field   (ctl_field),
        .to_left (field_left),
        .routed  (field_word)
    );

    // Carry enters at position 35 and only leaves P if every bit is one
    carry_adder #(
        .WIDTH (WORD_W)
    ) u_adder (
        .a         (memory_buffer_word_ff),
        .carry_in  (1'b1),
        .sum       (test_sum),
        .carry_out (test_carry)
    );

    // ==========================================================
    // Sequencing and buffer word selection
    always_comb begin
        nxt_state      = state_ff;
        nxt_op         = op_ff;
        nxt_buffer     = memory_buffer_word_ff;
        nxt_mode       = upd_none;
        nxt_done       = 1'b0;
        nxt_store_we   = 1'b0;
        nxt_work_we    = 1'b0;
        nxt_jump_valid = 1'b0;
        case (state_ff)
            st_idle: begin
                if (take_start) begin
                    nxt_op = op_code;
                    case (op_code)
                        load_flags_from_memory,
                        write_flags_to_memory,
                        or_memory_into_flags,
                        invert_flags_by_memory,
                        clear_flags_by_memory: begin
                            nxt_state = st_mem;
                        end
                        set_right_flags_by_field,
                        set_left_flags_by_field: begin
                            nxt_buffer = field_word;
                            nxt_mode   = upd_or;
                            nxt_done   = 1'b1;
                        end
                        clear_right_flags_by_field,
                        clear_left_flags_by_field: begin
                            nxt_buffer = field_word;
                            nxt_mode   = upd_clear;
                            nxt_done   = 1'b1;
                        end
                        invert_right_flags_by_field,
                        invert_left_flags_by_field: begin
                            nxt_buffer = field_word;
                            nxt_mode   = upd_invert;
                            nxt_done   = 1'b1;
                        end
                        copy_flags_to_work_reg: begin
                            nxt_buffer  = program_flag_word_ff;
                            nxt_work_we = 1'b1;
                            nxt_done    = 1'b1;
                        end
                        copy_work_reg_to_flags: begin
                            nxt_buffer = work_reg_in;
                            nxt_mode   = upd_load;
                            nxt_done   = 1'b1;
                        end
                        or_work_reg_into_flags: begin
                            // Same path as the copy, minus the flag reset
                            nxt_buffer = work_reg_in;
                            nxt_mode   = upd_or;
                            nxt_done   = 1'b1;
                        end
                        clear_flags_by_work_reg: begin
                            nxt_buffer = work_reg_in;
                            nxt_mode   = upd_clear;
                            nxt_done   = 1'b1;
                        end
                        invert_flags_by_work_reg: begin
                            nxt_buffer = work_reg_in;
                            nxt_mode   = upd_invert;
                            nxt_done   = 1'b1;
                        end
                        jump_if_flags_set: begin
                            nxt_buffer = ~work_reg_in
                                       | program_flag_word_ff;
                            nxt_state  = st_test;
                        end
                        jump_if_flags_clear: begin
                            nxt_buffer = ~work_reg_in
                                       | ~program_flag_word_ff;
                            nxt_state  = st_test;
                        end
                        default: begin
                            nxt_done = 1'b1;
                        end
                    endcase
                end
            end
            st_mem: begin
                // Wait for the storage cycle; the sequencer may stretch it
                if (mem_valid) begin
                    nxt_state = st_idle;
                    nxt_done  = 1'b1;
                    case (op_ff)
                        write_flags_to_memory: begin
                            nxt_buffer   = program_flag_word_ff;
                            nxt_store_we = 1'b1;
                        end
                        load_flags_from_memory: begin
                            nxt_buffer = mem_word;
                            nxt_mode   = upd_load;
                        end
                        or_memory_into_flags: begin
                            nxt_buffer = mem_word;
                            nxt_mode   = upd_or;
                        end
                        invert_flags_by_memory: begin
                            nxt_buffer = mem_word;
                            nxt_mode   = upd_invert;
                        end
                        clear_flags_by_memory: begin
                            nxt_buffer = mem_word;
                            nxt_mode   = upd_clear;
                        end
                        default: begin
                            nxt_mode = upd_none;
                        end
                    endcase
                end
            end
            st_test: begin
                nxt_state      = st_idle;
                nxt_buffer     = test_sum;
                nxt_jump_valid = 1'b1;
                nxt_done       = 1'b1;
            end
            default: begin
                nxt_state = st_idle;
            end
        endcase
    end

    // ==========================================================
    // Flag update, fed only by the word entering the buffer
    always_comb begin
        case (nxt_mode)
            upd_load:   nxt_flags = nxt_buffer;
            upd_or:     nxt_flags = program_flag_word_ff | nxt_buffer;
            upd_clear:  nxt_flags = program_flag_word_ff & ~nxt_buffer;
            upd_invert: nxt_flags = program_flag_word_ff ^ nxt_buffer;
            default:    nxt_flags = program_flag_word_ff;
        endcase
    end

    // ==========================================================
    // State registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_ff <= st_idle;
            op_ff    <= no_op;
        end else begin
            state_ff <= nxt_state;
            op_ff    <= nxt_op;
        end
    end

    // Whole register written at once at the end of the last cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            program_flag_word_ff <= FLAG_RESET;
        end else begin
            program_flag_word_ff <= nxt_flags;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            memory_buffer_word_ff <= WORD_ZERO;
        end else begin
            memory_buffer_word_ff <= nxt_buffer;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != st_idle);
            done_ff <= nxt_done;
        end
    end

    // ==========================================================
    // Storage write port
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            store_word_ff <= WORD_ZERO;
            store_we_ff   <= 1'b0;
        end else begin
            store_we_ff <= nxt_store_we;
            if (nxt_store_we) begin
                store_word_ff <= nxt_buffer;
            end
        end
    end

    // ==========================================================
    // Work register write port: S and Q always written as zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            work_reg_out_ff <= {2'b00, WORD_ZERO};
            work_reg_we_ff  <= 1'b0;
        end else begin
            work_reg_we_ff <= nxt_work_we;
            if (nxt_work_we) begin
                work_reg_out_ff <= {2'b00, nxt_buffer};
            end
        end
    end

    // ==========================================================
    // Transfer decision
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            jump_valid_ff <= 1'b0;
            jump_taken_ff <= 1'b0;
        end else begin
            jump_valid_ff <= nxt_jump_valid;
            if (nxt_jump_valid) begin
                jump_taken_ff <= test_carry;
            end else begin
                jump_taken_ff <= 1'b0;
            end
        end
    end

endmodule // sense_indicator_flag_unit

// *** hw/flag_unit_pkg.sv ***
// What this block does
// - Load from memory copies storage word into all flags; storage unchanged
// - Store to memory writes all 36 flags to storage; flags unchanged
// - OR from memory sets flags where storage word bits are one
// - Invert from memory toggles flags where storage word bits are one
// - Clear from memory resets flags opposite storage one bits only
// - Set right half ORs control field into right half in fetch cycle
// - Set left half ORs control field into left half; right half kept
// - Clear right half resets right flags opposite field ones
// - Clear left half resets left flags opposite field ones
// - Invert right half toggles right flags opposite field ones
// - Invert left half toggles left flags opposite field ones
// - Copy flags to work register P,1-35; clear its Q and S
// - Copy work register P,1-35 into whole flag register
// - OR work register into flags, copy sequence without initial reset
// - Clear flags opposite work register one bits
// - Invert flags opposite work register one bits
// - Jump if every work register one faces a set flag
// - Jump if every work register one faces a clear flag
// - Test word goes to buffer and adder; carry out of P enables jump
// - Flags take input only from buffer; right field leaves left half zero
// - Left field routes control field bits 0-17 to buffer positions P-17
package flag_unit_pkg;

    // ==========================================================
    // Widths and reset values
    localparam int WORD_W = 36;
    localparam int HALF_W = 18;
    localparam int WORK_W = 38;
    localparam logic [0:35] FLAG_RESET = 36'h000000000;
    localparam logic [0:35] WORD_ZERO  = 36'h000000000;
    localparam logic [0:17] HALF_ZERO  = 18'h00000;

    // ==========================================================
    // Operations issued by the sequencer
    typedef enum logic [4:0] {
        no_op                       = 5'h00,
        load_flags_from_memory      = 5'h01,
        write_flags_to_memory       = 5'h02,
        or_memory_into_flags        = 5'h03,
        invert_flags_by_memory      = 5'h04,
        clear_flags_by_memory       = 5'h05,
        set_right_flags_by_field    = 5'h06,
        set_left_flags_by_field     = 5'h07,
        clear_right_flags_by_field  = 5'h08,
        clear_left_flags_by_field   = 5'h09,
        invert_right_flags_by_field = 5'h0a,
        invert_left_flags_by_field  = 5'h0b,
        copy_flags_to_work_reg      = 5'h0c,
        copy_work_reg_to_flags      = 5'h0d,
        or_work_reg_into_flags      = 5'h0e,
        clear_flags_by_work_reg     = 5'h0f,
        invert_flags_by_work_reg    = 5'h10,
        jump_if_flags_set           = 5'h11,
        jump_if_flags_clear         = 5'h12
    } op_e;

    // ==========================================================
    // Flag update modes and sequencer states
    typedef enum logic [2:0] {
        upd_none   = 3'b000,
        upd_load   = 3'b001,
        upd_or     = 3'b010,
        upd_clear  = 3'b011,
        upd_invert = 3'b100
    } upd_e;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_mem  = 2'b01,
        st_test = 2'b10
    } state_e;

endpackage

// *** hw/half_router.sv ***
`timescale 1ns/10ps
module half_router (
    input  wire logic [0:17] field,
    input  wire logic        to_left,
    output logic      [0:35] routed
);
    import flag_unit_pkg::*;

    // ==========================================================
    // Field placement; the other half is forced to zero
    always_comb begin
        if (to_left) begin
            routed = {field, HALF_ZERO};
        end else begin
            routed = {HALF_ZERO, field};
        end
    end
endmodule // half_router

// *** hw/carry_adder.sv ***
`timescale 1ns/10ps
module carry_adder #(
    parameter int WIDTH = 36
) (
    input  wire logic [0:WIDTH-1] a,
    input  wire logic             carry_in,
    output logic      [0:WIDTH-1] sum,
    output logic                  carry_out
);
    // ==========================================================
    // Ripple from the low-order end (highest index) toward P
    logic [0:WIDTH] carry;

    assign carry[WIDTH] = carry_in;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign sum[i]   = a[i] ^ carry[i+1];
            assign carry[i] = a[i] & carry[i+1];
        end
    endgenerate

    assign carry_out = carry[0];
endmodule // carry_adder

// *** verif/flag_mem_model.sv ***
`timescale 1ns/10ps
module flag_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        busy_ff,
    input  wire logic        store_we_ff,
    input  wire logic [0:35] store_word_ff,
    input  wire logic [0:35] rd_word,
    input  wire logic [3:0]  lag,
    output logic             mem_valid,
    output logic      [0:35] mem_word,
    output logic      [0:35] stored
);
    // ==========================================================
    // Storage cycle answers after a chosen lag
    logic [3:0] cnt;
    initial begin
        mem_valid = 1'b0;
        mem_word  = 36'h000000000;
        stored    = 36'h000000000;
        cnt       = 4'h0;
    end
    // Word not presented shows its inverse, so a stale read cannot pass
    always @(negedge ref_clk) begin
        mem_valid = busy_ff && resetn && (cnt == lag);
        mem_word  = mem_valid ? rd_word : ~rd_word;
        cnt       = busy_ff ? cnt + 4'h1 : 4'h0;
    end
    always @(posedge ref_clk) begin
        if (store_we_ff) begin
            stored <= store_word_ff;
        end
    end
endmodule // flag_mem_model

// *** verif/sense_indicator_flag_unit_sva.sv ***
`timescale 1ns/10ps
module sense_indicator_flag_unit_sva (
    input wire logic               ref_clk,
    input wire logic               resetn,
    input wire logic               op_start,
    input wire flag_unit_pkg::op_e op_code,
    input wire logic      [0:17]   ctl_field,
    input wire logic               mem_valid,
    input wire logic      [0:35]   mem_word,
    input wire logic      [0:35]   work_reg_in,
    input wire logic      [0:35]   program_flag_word_ff,
    input wire logic      [0:35]   memory_buffer_word_ff,
    input wire logic               busy_ff,
    input wire logic               done_ff,
    input wire logic      [0:35]   store_word_ff,
    input wire logic               store_we_ff,
    input wire logic      [0:37]   work_reg_out_ff,
    input wire logic               work_reg_we_ff,
    input wire logic               jump_valid_ff,
    input wire logic               jump_taken_ff
);
    import flag_unit_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    op_e op_q_ff;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            op_q_ff <= no_op;
        end else if (op_start && !busy_ff) begin
            op_q_ff <= op_code;
        end
    end
    // ==========================================================
    // Sequences and properties
    sequence s_go(op_e op);
        op_start && !busy_ff && op_code == op;
    endsequence
    sequence s_mem(op_e op);
        busy_ff && mem_valid && op_q_ff == op;
    endsequence
    property p_set_right;
        s_go(set_right_flags_by_field) |=> done_ff && !busy_ff
            && memory_buffer_word_ff == {HALF_ZERO, $past(ctl_field)}
            && program_flag_word_ff == ($past(program_flag_word_ff)
               | {HALF_ZERO, $past(ctl_field)});
    endproperty
    property p_set_left;
        s_go(set_left_flags_by_field) |=> program_flag_word_ff ==
            ($past(program_flag_word_ff) | {$past(ctl_field), HALF_ZERO});
    endproperty
    property p_to_work;
        s_go(copy_flags_to_work_reg) |=> work_reg_we_ff
            && work_reg_out_ff == {2'b00, $past(program_flag_word_ff)}
            && $stable(program_flag_word_ff);
    endproperty
    property p_from_work;
        s_go(copy_work_reg_to_flags) |=>
            program_flag_word_ff == $past(work_reg_in);
    endproperty
    property p_jump_set;
        s_go(jump_if_flags_set) |=> busy_ff && memory_buffer_word_ff ==
            (~$past(work_reg_in) | $past(program_flag_word_ff))
            ##1 jump_valid_ff && done_ff && jump_taken_ff ==
            (&(~$past(work_reg_in, 2) | $past(program_flag_word_ff, 2)));
    endproperty
    property p_jump_clear;
        s_go(jump_if_flags_clear) |=> busy_ff ##1 jump_valid_ff
            && jump_taken_ff ==
            (&(~$past(work_reg_in, 2) | ~$past(program_flag_word_ff, 2)));
    endproperty
    property p_load;
        s_mem(load_flags_from_memory) |=> done_ff && !busy_ff
            && program_flag_word_ff == $past(mem_word);
    endproperty
    property p_store;
        s_mem(write_flags_to_memory) |=> store_we_ff
            && store_word_ff == $past(program_flag_word_ff)
            && $stable(program_flag_word_ff);
    endproperty
    a_set_right: assert property (p_set_right)
        else $error("set right half update wrong");
    a_set_left: assert property (p_set_left)
        else $error("set left half update wrong");
    a_to_work: assert property (p_to_work)
        else $error("flags to work register wrong");
    a_from_work: assert property (p_from_work)
        else $error("work register to flags wrong");
    a_jump_set: assert property (p_jump_set)
        else $error("set test decision wrong");
    a_jump_clear: assert property (p_jump_clear)
        else $error("clear test decision wrong");
    a_load: assert property (p_load)
        else $error("load from storage wrong");
    a_store: assert property (p_store)
        else $error("store to storage wrong");
endmodule // sense_indicator_flag_unit_sva

bind sense_indicator_flag_unit sense_indicator_flag_unit_sva chk_u (
    .ref_clk(ref_clk), .resetn(resetn), .op_start(op_start),
    .op_code(op_code), .ctl_field(ctl_field), .mem_valid(mem_valid),
    .mem_word(mem_word), .work_reg_in(work_reg_in),
    .program_flag_word_ff(program_flag_word_ff),
    .memory_buffer_word_ff(memory_buffer_word_ff), .busy_ff(busy_ff),
    .done_ff(done_ff), .store_word_ff(store_word_ff),
    .store_we_ff(store_we_ff), .work_reg_out_ff(work_reg_out_ff),
    .work_reg_we_ff(work_reg_we_ff), .jump_valid_ff(jump_valid_ff),
    .jump_taken_ff(jump_taken_ff)
);

// *** verif/tb_sense_indicator_flag_unit.sv ***
`timescale 1ns/10ps
module tb_sense_indicator_flag_unit;
    import flag_unit_pkg::*;
    logic        ref_clk     = 1'b0;
    logic        resetn      = 1'b0;
    logic        op_start    = 1'b0;
    op_e         op_code     = no_op;
    logic [0:17] ctl_field   = 18'h00000;
    logic [0:35] work_reg_in = 36'h000000000;
    logic [0:35] rd_word     = 36'h000000000;
    logic [3:0]  lag         = 4'h0;
    logic        mem_valid, busy_ff, done_ff, store_we_ff;
    logic        work_reg_we_ff, jump_valid_ff, jump_taken_ff;
    logic [0:35] mem_word, flags, buf_word, store_word_ff, stored, ef;
    logic [0:37] work_out;
    logic [0:1]  jt;
    int          err_count = 0;
    int          compares  = 0;
    op_e         mops[4] = '{load_flags_from_memory, or_memory_into_flags,
                             invert_flags_by_memory, clear_flags_by_memory};
    op_e         wops[4] = '{copy_work_reg_to_flags, or_work_reg_into_flags,
                           clear_flags_by_work_reg, invert_flags_by_work_reg};
    op_e         fops[6] = '{set_right_flags_by_field,
        set_left_flags_by_field, clear_right_flags_by_field,
        clear_left_flags_by_field, invert_right_flags_by_field,
        invert_left_flags_by_field};
    int          mk[4] = '{3, 0, 2, 1};
    int          wk[4] = '{3, 0, 1, 2};
    logic [0:35] mw[4] = '{36'h80000000f, 36'h0f0f0f0f0, 36'h123456789,
                           36'h00ff00ff1};
    always #12.5 ref_clk = ~ref_clk;
    sense_indicator_flag_unit dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .op_start(op_start),
        .op_code(op_code), .ctl_field(ctl_field), .mem_valid(mem_valid),
        .mem_word(mem_word), .work_reg_in(work_reg_in),
        .program_flag_word_ff(flags), .memory_buffer_word_ff(buf_word),
        .busy_ff(busy_ff), .done_ff(done_ff),
        .store_word_ff(store_word_ff), .store_we_ff(store_we_ff),
        .work_reg_out_ff(work_out), .work_reg_we_ff(work_reg_we_ff),
        .jump_valid_ff(jump_valid_ff), .jump_taken_ff(jump_taken_ff)
    );
    flag_mem_model mem_u (
        .ref_clk(ref_clk), .resetn(resetn), .busy_ff(busy_ff),
        .store_we_ff(store_we_ff), .store_word_ff(store_word_ff),
        .rd_word(rd_word), .lag(lag), .mem_valid(mem_valid),
        .mem_word(mem_word), .stored(stored)
    );
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [0:37] seen, input logic [0:37] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Called at a falling edge; returns at the falling edge showing done
    task automatic run_op(input op_e op, input logic [0:17] f,
                          input logic [0:35] ac);
        int n;
        n = 0;
        // One edge passes first, so op_start never falls and rises at once
        @(negedge ref_clk);
        op_start = 1'b1;
        op_code = op;
        ctl_field = f;
        work_reg_in = ac;
        @(negedge ref_clk);
        op_start = 1'b0;
        while (done_ff !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        jt = {jump_valid_ff, jump_taken_ff};
        if (n == 40) begin
            err_count++;
        end
    endtask
    function automatic logic [0:35] upd(input logic [0:35] f, m,
                                        input int k);
        case (k)
            0: upd = f | m;
            1: upd = f & ~m;
            2: upd = f ^ m;
            default: upd = m;
        endcase
    endfunction
    // ==========================================================
    // Tests
    initial begin
        int i;
        repeat (10) @(negedge ref_clk);
        resetn = 1'b1;
        check(flags, 36'h000000000);
        for (i = 0; i < 4; i++) begin
            rd_word = mw[i];
            lag = i[3:0];
            run_op(mops[i], 18'h00000, 36'h000000000);
            ef = upd(ef, mw[i], mk[i]);
            if (i == 0) ef = mw[0];
            check(flags, ef);
        end
        lag = 4'h2;
        run_op(write_flags_to_memory, 18'h00000, 36'h000000000);
        @(negedge ref_clk);
        check(stored, ef);
        check(flags, ef);
        for (i = 0; i < 6; i++) begin
            run_op(fops[i], 18'h2a5c3, 36'h000000000);
            ef = upd(ef, (i % 2) ? {18'h2a5c3, HALF_ZERO}
                                 : {HALF_ZERO, 18'h2a5c3}, i / 2);
            check(flags, ef);
        end
        for (i = 0; i < 4; i++) begin
            run_op(wops[i], 18'h00000, mw[3 - i]);
            ef = upd(ef, mw[3 - i], wk[i]);
            check(flags, ef);
        end
        run_op(copy_flags_to_work_reg, 18'h00000, 36'h000000000);
        check(work_out, {2'b00, ef});
        check(flags, ef);
        run_op(no_op, 18'h3ffff, 36'hfffffffff);
        check(flags, ef);
        for (i = 0; i < 4; i++) begin
            run_op((i < 2) ? jump_if_flags_set : jump_if_flags_clear,
                   18'h00000, (i % 2) ? ~ef : ef);
            check(jt, {1'b1, (i < 2) ? &(~((i % 2) ? ~ef : ef) | ef)
                : &(~((i % 2) ? ~ef : ef) | ~ef)});
            check(flags, ef);
        end
        test_done();
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        err_count++;
        test_done();
    end
endmodule // tb_sense_indicator_flag_unit
